// >>> rtl/awc_pkg.sv
// Package for the converter window comparator: register addresses, resets, layout.
// Assumes an 8-bit special-function register bus with one address per register.
package awc_pkg;
   localparam logic [7:0] ADDR_GREATER_THAN = 8'hC5;
   localparam logic [7:0] ADDR_LESS_THAN    = 8'hC7;
   localparam logic [7:0] ADDR_RESULT       = 8'hBF;
   localparam logic [7:0] ADDR_CONTROL      = 8'hE8;
   localparam logic [7:0] RST_GREATER_THAN  = 8'hFF;
   localparam logic [7:0] RST_LESS_THAN     = 8'h00;
   localparam logic [7:0] RST_RESULT        = 8'h00;
   localparam int         BIT_BUSY          = 4;
   localparam int         BIT_CONV_DONE     = 5;
   localparam int         BIT_WINDOW_MATCH  = 1;
   localparam int         BIT_ENABLE        = 7;
   localparam int         CONV_SAR_CLOCKS   = 16;
   localparam int         SAR_DIV_DEFAULT   = 1;
endpackage

// >>> rtl/awc_window_comparator.sv
// Window comparator with its limit registers, result register and control bits.
// Assumes a synchronous 8-bit register bus; conversion start and result come from
// the converter on the same clock.
//
// Function
// - Compare each new result against both limits
// - Greater-than limit register C5, resets FF
// - Less-than limit register C7, resets 00
// - Limits ordered up: match strictly inside band
// - Limits ordered down: match strictly outside band
// - Flag readable and usable as interrupt
// - Unsigned 8-bit compare of result and limits
// - Conversion lasts sixteen conversion clock periods
// - Match flag is control register bit one
// - Compared value is the new sample, stored to result register BF
`timescale 1ns/100ps
module awc_window_comparator #(
   parameter int SAR_DIV = awc_pkg::SAR_DIV_DEFAULT
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       conv_start,
   input  wire logic [7:0] conv_sample,
   input  wire logic       win_irq_en,
   output logic            win_irq,
   output logic            conv_busy
);
   localparam int CNT_W = $clog2(awc_pkg::CONV_SAR_CLOCKS * SAR_DIV + 1);
   localparam logic [CNT_W-1:0] CONV_CYCLES = CNT_W'(awc_pkg::CONV_SAR_CLOCKS * SAR_DIV);

   logic [7:0]       greater_than_limit, next_greater_than_limit;
   logic [7:0]       less_than_limit, next_less_than_limit;
   logic [7:0]       conversion_result_byte, next_conversion_result_byte;
   logic             window_match_flag, next_window_match_flag;
   logic             conv_done_flag, next_conv_done_flag;
   logic             conv_enable, next_conv_enable;
   logic [CNT_W-1:0] conv_cnt, next_conv_cnt;
   logic             next_conv_busy;
   logic             next_win_irq;
   logic [7:0]       next_reg_rdata;
   logic             conv_end;
   logic             in_window;
   logic             wr_ctrl;

   ////////////////////////////////////////////////////////////////////////
   // Conversion timing
   assign conv_end = conv_busy && (conv_cnt == CNT_W'(1));

   always_comb begin
      next_conv_cnt = conv_cnt;
      next_conv_busy = conv_busy;
      if (conv_busy) begin
         next_conv_cnt = conv_cnt - CNT_W'(1);
         if (conv_end) begin
            next_conv_busy = 1'b0;
         end
      end else if (conv_enable && (conv_start ||
                  (wr_ctrl && reg_wdata[awc_pkg::BIT_BUSY]))) begin
         next_conv_cnt = CONV_CYCLES;
         next_conv_busy = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window decision
   // Unsigned compares; order of limits picks inside or outside band
   always_comb begin
      if (less_than_limit > greater_than_limit) begin
         in_window = (conv_sample < less_than_limit) &&
                     (conv_sample > greater_than_limit);
      end else begin
         in_window = (conv_sample < less_than_limit) ||
                     (conv_sample > greater_than_limit);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   assign wr_ctrl = reg_wr && (reg_addr == awc_pkg::ADDR_CONTROL);

   always_comb begin
      next_greater_than_limit = greater_than_limit;
      next_less_than_limit = less_than_limit;
      next_conversion_result_byte = conversion_result_byte;
      next_window_match_flag = window_match_flag;
      next_conv_done_flag = conv_done_flag;
      next_conv_enable = conv_enable;
      if (reg_wr) begin
         if (reg_addr == awc_pkg::ADDR_GREATER_THAN) begin
            next_greater_than_limit = reg_wdata;
         end else if (reg_addr == awc_pkg::ADDR_LESS_THAN) begin
            next_less_than_limit = reg_wdata;
         end else if (reg_addr == awc_pkg::ADDR_RESULT) begin
            next_conversion_result_byte = reg_wdata;
         end else if (reg_addr == awc_pkg::ADDR_CONTROL) begin
            next_conv_enable = reg_wdata[awc_pkg::BIT_ENABLE];
            next_conv_done_flag = reg_wdata[awc_pkg::BIT_CONV_DONE];
            next_window_match_flag = reg_wdata[awc_pkg::BIT_WINDOW_MATCH];
         end
      end
      // Hardware events last so a same-cycle clear loses
      if (conv_end) begin
         next_conversion_result_byte = conv_sample;
         next_conv_done_flag = 1'b1;
         if (in_window) begin
            next_window_match_flag = 1'b1;
         end
      end
      next_win_irq = next_window_match_flag && win_irq_en;
      next_reg_rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == awc_pkg::ADDR_GREATER_THAN) begin
            next_reg_rdata = greater_than_limit;
         end else if (reg_addr == awc_pkg::ADDR_LESS_THAN) begin
            next_reg_rdata = less_than_limit;
         end else if (reg_addr == awc_pkg::ADDR_RESULT) begin
            next_reg_rdata = conversion_result_byte;
         end else if (reg_addr == awc_pkg::ADDR_CONTROL) begin
            next_reg_rdata[awc_pkg::BIT_ENABLE] = conv_enable;
            next_reg_rdata[awc_pkg::BIT_CONV_DONE] = conv_done_flag;
            next_reg_rdata[awc_pkg::BIT_BUSY] = conv_busy;
            next_reg_rdata[awc_pkg::BIT_WINDOW_MATCH] = window_match_flag;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         greater_than_limit <= awc_pkg::RST_GREATER_THAN;
         less_than_limit <= awc_pkg::RST_LESS_THAN;
         conversion_result_byte <= awc_pkg::RST_RESULT;
         window_match_flag <= 1'b0;
         conv_done_flag <= 1'b0;
         conv_enable <= 1'b0;
         conv_cnt <= '0;
         conv_busy <= 1'b0;
         win_irq <= 1'b0;
         reg_rdata <= 8'h00;
      end else if (ce) begin
         greater_than_limit <= next_greater_than_limit;
         less_than_limit <= next_less_than_limit;
         conversion_result_byte <= next_conversion_result_byte;
         window_match_flag <= next_window_match_flag;
         conv_done_flag <= next_conv_done_flag;
         conv_enable <= next_conv_enable;
         conv_cnt <= next_conv_cnt;
         conv_busy <= next_conv_busy;
         win_irq <= next_win_irq;
         reg_rdata <= next_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Busy length counted apart from conv_cnt, so a wrong end count shows
   logic [CNT_W-1:0] busy_len, next_busy_len;

   always_comb begin
      next_busy_len = busy_len;
      if (!conv_busy) begin
         next_busy_len = '0;
      end else if (busy_len != '1) begin
         next_busy_len = busy_len + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_len <= '0;
      end else if (ce) begin
         busy_len <= next_busy_len;
      end
   end

   chk_busy_length: assert property (@(posedge clk) disable iff (!nrst)
      $fell(conv_busy) |-> busy_len == CONV_CYCLES)
      else $error("conversion length wrong");
   chk_start_refused: assert property (@(posedge clk) disable iff (!nrst)
      !conv_busy && !conv_enable |=> !conv_busy)
      else $error("conversion started while disabled");
   chk_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
      !ce |=> $stable(conv_cnt) && $stable(conv_busy) && $stable(window_match_flag))
      else $error("state moved while clock enable low");
   chk_busy_bound: assert property (@(posedge clk) disable iff (!nrst)
      $rose(conv_busy) |-> ##[1:1000] !conv_busy)
      else $error("conversion never ended");
   chk_match_sets: assert property (@(posedge clk) disable iff (!nrst)
      ce && conv_end && in_window |=> window_match_flag)
      else $error("match did not set flag");
   chk_miss_keeps: assert property (@(posedge clk) disable iff (!nrst)
      ce && conv_end && !in_window && !wr_ctrl |=> window_match_flag == $past(window_match_flag))
      else $error("miss changed flag");
   chk_set_wins: assert property (@(posedge clk) disable iff (!nrst)
      ce && conv_end && in_window && wr_ctrl |=> window_match_flag)
      else $error("clear beat new match");
   chk_no_self_clear: assert property (@(posedge clk) disable iff (!nrst)
      window_match_flag && !(ce && wr_ctrl) |=> window_match_flag)
      else $error("flag cleared by itself");
   chk_inside_band: assert property (@(posedge clk) disable iff (!nrst)
      less_than_limit > greater_than_limit && conv_sample <= greater_than_limit |-> !in_window)
      else $error("inside band wrong");
   chk_outside_band: assert property (@(posedge clk) disable iff (!nrst)
      less_than_limit <= greater_than_limit && conv_sample > greater_than_limit |-> in_window)
      else $error("outside band wrong");
   chk_result_load: assert property (@(posedge clk) disable iff (!nrst)
      ce && conv_end |=> conversion_result_byte == $past(conv_sample))
      else $error("result not stored");
   chk_irq_follow: assert property (@(posedge clk) disable iff (!nrst)
      ce ##1 ce |-> win_irq == (window_match_flag && $past(win_irq_en)))
      else $error("irq mismatch");

   cov_inside: cover property (@(posedge clk) conv_end && in_window && less_than_limit > greater_than_limit);
   cov_outside: cover property (@(posedge clk) conv_end && in_window && less_than_limit <= greater_than_limit);
   cov_miss: cover property (@(posedge clk) conv_end && !in_window);
   cov_race: cover property (@(posedge clk) conv_end && in_window && wr_ctrl);
   cov_frozen: cover property (@(posedge clk) conv_busy && !ce);
endmodule // awc_window_comparator

// >>> tb/awc_conv_model.sv
// Converter result path model feeding the window comparator.
// Assumes the block samples conv_sample while conv_busy is high.
`timescale 1ns/100ps
module awc_conv_model (
   input  wire logic       conv_busy,
   input  wire logic [7:0] value,
   output logic      [7:0] conv_sample
);
   // Inverse outside conversion, so early or late sampling shows
   always_comb conv_sample = conv_busy ? value : ~value;
endmodule // awc_conv_model

// >>> tb/tb.sv
// Testbench for the window comparator: register tasks and a table of conversions.
// Assumes SAR_DIV of 1 and the converter model on the sample input.
`timescale 1ns/100ps
module tb;
   logic        clk        = 1'b0;
   logic        nrst       = 1'b0;
   logic        ce         = 1'b1;
   logic        reg_wr     = 1'b0;
   logic        reg_rd     = 1'b0;
   logic        conv_start = 1'b0;
   logic        win_irq_en = 1'b0;
   logic [7:0]  reg_addr   = 8'h00;
   logic [7:0]  reg_wdata  = 8'h00;
   logic [7:0]  smp_value  = 8'h00;
   logic [7:0]  reg_rdata, conv_sample;
   logic        win_irq, conv_busy;
   int          n_errors   = 0;
   int          checked    = 0;
   int          n;
   // Limit less, limit greater, sample, flags: bit0 match, bit1 keep flag
   logic [31:0] rows [13] = '{32'h20101501, 32'h20101101, 32'h20104003, 32'h20101000,
      32'h20102000, 32'h10200F01, 32'h10201000, 32'h1020FF01, 32'h10202000, 32'h10202101,
      32'h00FF0000, 32'hFF008001, 32'hFF00FF00};

   awc_window_comparator #(.SAR_DIV(1)) dut_u (.clk(clk), .nrst(nrst), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_sample(conv_sample),
      .win_irq_en(win_irq_en), .win_irq(win_irq), .conv_busy(conv_busy));
   awc_conv_model model_u (.conv_busy(conv_busy), .value(smp_value), .conv_sample(conv_sample));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // Read data is registered, so it is taken one edge after the strobe
   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(what, reg_rdata & m, exp);
   endtask
   task automatic wait_idle;
      n = 0;
      for (int k = 0; k < 40; k++) begin
         if (conv_busy === 1'b1)
            n++;
         else if (n > 0)
            break;
         @(negedge clk);
      end
      if (conv_busy !== 1'b0) begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic conv(input logic [7:0] s);
      smp_value = s;
      @(negedge clk);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      wait_idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      rdchk("greater reset", 8'hC5, 8'hFF, 8'hFF);
      rdchk("less reset", 8'hC7, 8'hFF, 8'h00);
      rdchk("control reset", 8'hE8, 8'hFF, 8'h00);
      wr(8'h00, 8'h5A);
      rdchk("unmapped", 8'h00, 8'hFF, 8'h00);
      for (int i = 0; i < 13; i++) begin
         win_irq_en = i[0];
         wr(8'hC7, rows[i][31:24]);
         wr(8'hC5, rows[i][23:16]);
         rdchk("less limit", 8'hC7, 8'hFF, rows[i][31:24]);
         rdchk("greater limit", 8'hC5, 8'hFF, rows[i][23:16]);
         // Clearing write keeps the converter enabled
         if (!rows[i][1])
            wr(8'hE8, 8'h80);
         conv(rows[i][15:8]);
         chk("busy cycles", n[7:0], 8'h10);
         rdchk("match flag", 8'hE8, 8'h02, {6'h00, rows[i][0], 1'b0});
         rdchk("result", 8'hBF, 8'hFF, rows[i][15:8]);
         chk("irq", {7'h00, win_irq}, {7'h00, rows[i][0] & i[0]});
      end
      // Clear lands on the end-of-conversion edge; the new match must win
      smp_value = 8'h40;
      @(negedge clk);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      repeat (14) @(negedge clk);
      wr(8'hE8, 8'h80);
      rdchk("set wins", 8'hE8, 8'hB2, 8'hA2);
      // Disabled converter refuses both start paths
      wr(8'hE8, 8'h00);
      @(negedge clk);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      wr(8'hE8, 8'h10);
      chk("start refused", {7'h00, conv_busy}, 8'h00);
      // Start by the busy bit, then hold ce low for five edges
      win_irq_en = 1'b1;
      smp_value = 8'h01;
      wr(8'hE8, 8'h80);
      wr(8'hE8, 8'h90);
      ce = 1'b0;
      repeat (5) @(negedge clk);
      chk("busy frozen", {7'h00, conv_busy}, 8'h01);
      ce = 1'b1;
      wait_idle();
      chk("frozen busy cycles", n[7:0], 8'h10);
      rdchk("frozen match", 8'hE8, 8'h02, 8'h02);
      chk("irq set", {7'h00, win_irq}, 8'h01);
      // Reset after the conversion has ended returns every register to its reset value
      @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      chk("irq in reset", {7'h00, win_irq}, 8'h00);
      nrst = 1'b1;
      rdchk("greater again", 8'hC5, 8'hFF, 8'hFF);
      rdchk("less again", 8'hC7, 8'hFF, 8'h00);
      rdchk("control again", 8'hE8, 8'hFF, 8'h00);
      rdchk("result again", 8'hBF, 8'hFF, 8'h00);
      wr(8'hBF, 8'h3C);
      rdchk("result written", 8'hBF, 8'hFF, 8'h3C);
      test_done();
   end
endmodule // tb
